/* pkg/dvr_pkg.sv */
// shared constants and types of the receiver pixel output block
// assumes a 100 MHz ref_clk and decoded link channels arriving on the link clock
package dvr_pkg;
   localparam int CH_W                  = 8;
   localparam int WORD_W                = 3 * CH_W + 6;
   // word layout: blue, green, red, then control bits and data enable
   localparam int F_BLUE_LSB            = 0;
   localparam int F_GREEN_LSB           = 8;
   localparam int F_RED_LSB             = 16;
   localparam int F_HSYNC               = 24;
   localparam int F_VSYNC               = 25;
   localparam int F_CONTROL_BIT_FIRST                = 26;
   localparam int F_CONTROL_BIT_SECOND                = 27;
   localparam int F_CONTROL_BIT_THIRD                = 28;
   localparam int F_DE                  = 29;
   localparam int PIX_BUS_W             = 3 * CH_W;
   localparam int FIFO_DEPTH            = 16;
   localparam logic [WORD_W-1:0] WORD_RESET = 30'h0000_0000;
   localparam logic [PIX_BUS_W-1:0] BUS_RESET = 24'h00_0000;
   // timing, ref clock in ns
   localparam int REF_CLK_PERIOD_NS     = 10;
   // pixel period the transmitter must keep, in ps
   localparam int PIX_TIME_MIN_PS       = 6060;
   localparam int PIX_TIME_MAX_PS       = 40000;
   // data enable may sit still for a whole vertical blank, so this is long
   localparam int LINK_IDLE_TIMEOUT_US  = 50000;
   localparam int LINK_IDLE_TIMEOUT_CYCLES = LINK_IDLE_TIMEOUT_US * 1000 / REF_CLK_PERIOD_NS;
   localparam int OUT_CLK_HALF_NS       = 20;
   localparam int OUT_HALF_CYCLES_RAW   = OUT_CLK_HALF_NS / REF_CLK_PERIOD_NS;
   localparam int OUT_HALF_CYCLES       = (OUT_HALF_CYCLES_RAW < 1) ? 1 : OUT_HALF_CYCLES_RAW;
   typedef enum logic [3:0] {
      ST_FIRST  = 4'h1,
      ST_SECOND = 4'h2,
      ST_LOW    = 4'h4,
      ST_HIGH   = 4'h8
   } dvr_out_state_t;
endpackage

/* pkg/dvr_stream_if.sv */
// valid/ready word stream between the block's own modules
// assumes source and sink share one clock
`timescale 1ns/1ns
interface dvr_stream_if #(
   parameter int W = 30
);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* verification/dvr_pixel_out_bench.sv */
// self-checking bench for the pixel output block
// assumes the transmitter model drives the link and the port checker is bound below
`timescale 1ns/1ns
module dvr_pixel_out_bench;
   import dvr_pkg::*;
   localparam int IDLE = 200;
   logic                 ref_clk = 1'h0;
   logic                 arst_n = 1'h0;
   logic                 pixels_per_clock_select = 1'h0;
   logic                 stagger_select_n = 1'h1;
   logic                 output_driver_shutdown_n = 1'h1;
   logic                 link_clk, link_de, link_ch1_ctl;
   logic [CH_W-1:0]      link_ch0_data, link_ch1_data, link_ch2_data;
   logic [1:0]           link_ch0_ctl, link_ch2_ctl;
   logic [PIX_BUS_W-1:0] even_pixel_bus, odd_pixel_bus;
   logic                 output_pixel_clock, data_enable_out, hsync_out, vsync_out, opc_q;
   logic                 control_bit_first, control_bit_second, control_bit_third;
   logic                 link_active_flag, drivers_oe, fifo_overflow;
   logic [53:0]          seen[$], want[$];
   logic [29:0]          half;
   logic [4:0]           hold_c = 5'h00;
   bit                   two = 1'b0, half_v = 1'b0;
   int                   fails = 0, checked = 0;
   always #5 ref_clk = ~ref_clk;
   dvr_tx_model tx (.link_clk(link_clk), .link_de(link_de), .link_ch0_data(link_ch0_data),
      .link_ch0_ctl(link_ch0_ctl), .link_ch1_data(link_ch1_data), .link_ch1_ctl(link_ch1_ctl),
      .link_ch2_data(link_ch2_data), .link_ch2_ctl(link_ch2_ctl));
   dvr_pixel_out #(.IDLE_TIMEOUT_CYCLES(IDLE)) DUT (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk),
      .link_de(link_de), .link_ch0_data(link_ch0_data), .link_ch0_ctl(link_ch0_ctl),
      .link_ch1_data(link_ch1_data), .link_ch1_ctl(link_ch1_ctl), .link_ch2_data(link_ch2_data),
      .link_ch2_ctl(link_ch2_ctl), .pixels_per_clock_select(pixels_per_clock_select),
      .stagger_select_n(stagger_select_n), .output_driver_shutdown_n(output_driver_shutdown_n),
      .even_pixel_bus(even_pixel_bus), .odd_pixel_bus(odd_pixel_bus), .output_pixel_clock(output_pixel_clock),
      .data_enable_out(data_enable_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
      .control_bit_first(control_bit_first), .control_bit_second(control_bit_second),
      .control_bit_third(control_bit_third), .link_active_flag(link_active_flag),
      .drivers_oe(drivers_oe), .fifo_overflow(fifo_overflow));
   // taken after the rise, when a staggered odd pixel has settled as well
   always @(negedge ref_clk) begin
      opc_q <= output_pixel_clock;
      if (arst_n && opc_q === 1'h0 && output_pixel_clock === 1'h1)
         seen.push_back({data_enable_out, control_bit_third, control_bit_second, control_bit_first,
                         vsync_out, hsync_out, even_pixel_bus, odd_pixel_bus});
   end
   task automatic stop_test;
      begin
         $display("checked %0d, fails %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task automatic cmp_rec(input logic [53:0] got, input logic [53:0] exp);
      begin
         checked++;
         if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t output word %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      begin
         checked++;
         if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s", $time, what);
         end
      end
   endtask
   // blank words set the controls and zero the pixel; active words keep the last controls
   task automatic xmit(input logic de, input logic [23:0] px, input logic [4:0] c);
      logic [29:0] e;
      begin
         if (!de) hold_c = c;
         e = {de, hold_c, de ? px : 24'h000000};
         if (!two) want.push_back({e, 24'h000000});
         else if (half_v) begin
            want.push_back({half, e[23:0]});
            half_v = 1'b0;
         end else begin
            half = e;
            half_v = 1'b1;
         end
         tx.send(de, px, c);
      end
   endtask
   task automatic drain;
      int n;
      begin
         for (n = 0; n < 600 && seen.size() < want.size(); n++)
            @(negedge ref_clk);
         if (seen.size() < want.size()) begin
            fails++;
            $display("[FAIL] %0t output words missing", $time);
            stop_test;
         end else begin
            while (want.size() > 0)
               cmp_rec(seen.pop_front(), want.pop_front());
            cmp_bit(seen.size() == 0, 1'h1, "extra output words");
         end
      end
   endtask
   initial begin
      #900000;
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test;
   end
   initial begin
      fork
         repeat (16) @(negedge ref_clk);
         repeat (3) tx.send(1'h0, 24'h000000, 5'h00);
      join
      @(negedge ref_clk);
      arst_n = 1'h1;
      // link side leaves reset on its second edge, so prime it with idle words first
      repeat (3) tx.send(1'h0, 24'h000000, 5'h00);
      repeat (20) @(negedge ref_clk);
      seen.delete();
      for (int i = 0; i < 6; i++) begin
         xmit(1'h0, 24'h000000, 5'h01 << i);
         xmit(1'h1, {8'hC0 | 8'(i), 8'h50 | 8'(i), 8'h30 | 8'(i)}, 5'h1F);
      end
      drain;
      cmp_bit(link_active_flag, 1'h1, "link flag low while data enable toggles");
      for (int m = 0; m < 3; m++) begin
         @(negedge ref_clk);
         pixels_per_clock_select = (m < 2);
         stagger_select_n = (m == 0);
         two = (m < 2);
         repeat (20) @(negedge ref_clk);
         for (int i = 0; i < 4; i++)
            xmit(1'h1, {8'(16 * m + i), 8'hA0 + 8'(i), 8'h5A - 8'(m)}, 5'h00);
         drain;
      end
      // the shutdown pin is driven on its own, not tied to the link flag
      @(negedge ref_clk);
      output_driver_shutdown_n = 1'h0;
      repeat (6) @(negedge ref_clk);
      cmp_bit(drivers_oe, 1'h0, "drivers still on");
      output_driver_shutdown_n = 1'h1;
      repeat (6) @(negedge ref_clk);
      cmp_bit(drivers_oe, 1'h1, "drivers still off");
      repeat (IDLE + 40) @(negedge ref_clk);
      cmp_bit(link_active_flag, 1'h0, "link flag stuck high");
      cmp_bit(fifo_overflow, 1'h0, "words dropped");
      stop_test;
   end
endmodule
bind dvr_pixel_out dvr_pixel_out_props #(.IDLE_TIMEOUT_CYCLES(IDLE_TIMEOUT_CYCLES)) chk (.ref_clk(ref_clk),
   .arst_n(arst_n), .link_de(link_de), .pixels_per_clock_select(pixels_per_clock_select),
   .stagger_select_n(stagger_select_n), .output_driver_shutdown_n(output_driver_shutdown_n),
   .even_pixel_bus(even_pixel_bus), .odd_pixel_bus(odd_pixel_bus), .output_pixel_clock(output_pixel_clock),
   .link_active_flag(link_active_flag), .drivers_oe(drivers_oe), .fifo_overflow(fifo_overflow));

/* verification/dvr_pixel_out_props.sv */
// port assertions for the pixel output block, ref_clk domain only
// assumes it is bound onto dvr_pixel_out with the same idle timeout
`timescale 1ns/1ns
module dvr_pixel_out_props
   import dvr_pkg::*;
#(
   parameter int IDLE_TIMEOUT_CYCLES = 200
) (
   input wire logic                 ref_clk,
   input wire logic                 arst_n,
   input wire logic                 link_de,
   input wire logic                 pixels_per_clock_select,
   input wire logic                 stagger_select_n,
   input wire logic                 output_driver_shutdown_n,
   input wire logic [PIX_BUS_W-1:0] even_pixel_bus,
   input wire logic [PIX_BUS_W-1:0] odd_pixel_bus,
   input wire logic                 output_pixel_clock,
   input wire logic                 link_active_flag,
   input wire logic                 drivers_oe,
   input wire logic                 fifo_overflow
);
   logic [3:0] age;
   logic [7:0] pin_age;
   logic [1:0] pins_q;
   logic       de_q;
   int         de_idle;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // the driver enable checks wait until the internal reset copy and pin synchronisers have settled
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   // mode pins are latched per word, so only judge them once they have been steady a while
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pins_q <= 2'h0;
         pin_age <= 8'h00;
      end else begin
         pins_q <= {pixels_per_clock_select, stagger_select_n};
         if (pins_q != {pixels_per_clock_select, stagger_select_n}) pin_age <= 8'h00;
         else if (pin_age != 8'hFF) pin_age <= pin_age + 8'h01;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         de_q <= 1'h0;
         de_idle <= 0;
      end else begin
         de_q <= link_de;
         de_idle <= (de_q != link_de) ? 0 : de_idle + 1;
      end
   end
   a_oe_on: assert property ((age == 4'hF && output_driver_shutdown_n) [*4] |-> drivers_oe)
      else $error("drivers off while shutdown pin is high");
   a_oe_off: assert property ((age == 4'hF && !output_driver_shutdown_n) [*4] |-> !drivers_oe)
      else $error("drivers on while shutdown pin is low");
   a_odd_idle: assert property (pin_age > 8'h28 && !pixels_per_clock_select && $fell(output_pixel_clock)
      |-> odd_pixel_bus == 24'h000000) else $error("odd bus not low in one-pixel mode");
   a_flag_drop: assert property (de_idle > IDLE_TIMEOUT_CYCLES + 10 |-> !link_active_flag)
      else $error("link flag high without data enable toggling");
   a_flag_rise: assert property ($rose(link_active_flag) |-> de_idle < 20)
      else $error("link flag rose without a data enable edge");
   a_clk_low: assert property ($fell(output_pixel_clock) |-> ##1 !output_pixel_clock ##1 output_pixel_clock)
      else $error("output clock low phase not two cycles");
   a_clk_high: assert property ($rose(output_pixel_clock) |-> ##1 output_pixel_clock)
      else $error("output clock high phase too short");
   a_even_fall: assert property ($changed(even_pixel_bus) |-> $fell(output_pixel_clock))
      else $error("even bus moved off the falling output clock");
   a_odd_joint: assert property (pin_age > 8'h28 && pixels_per_clock_select && stagger_select_n
      && $changed(odd_pixel_bus) |-> $fell(output_pixel_clock)) else $error("odd bus not with even bus");
   a_odd_stagger_select_n: assert property (pin_age > 8'h28 && pixels_per_clock_select && !stagger_select_n
      && $changed(odd_pixel_bus) |-> $rose(output_pixel_clock)) else $error("odd bus not staggered");
   a_ovf_sticky: assert property (fifo_overflow |=> fifo_overflow)
      else $error("overflow flag cleared without reset");
   c_two_pix: cover property ($fell(output_pixel_clock) && pixels_per_clock_select && stagger_select_n);
   c_stagger_select_n: cover property ($rose(output_pixel_clock) && pixels_per_clock_select && !stagger_select_n);
   c_flag_drop: cover property ($fell(link_active_flag));
endmodule

/* verification/dvr_tx_model.sv */
// transmitter model: decoded link words and the link clock, one word per send
// assumes the caller spaces sends; the link clock stands still between words
`timescale 1ns/1ns
module dvr_tx_model
   import dvr_pkg::*;
(
   output logic            link_clk,
   output logic            link_de,
   output logic [CH_W-1:0] link_ch0_data,
   output logic [1:0]      link_ch0_ctl,
   output logic [CH_W-1:0] link_ch1_data,
   output logic            link_ch1_ctl,
   output logic [CH_W-1:0] link_ch2_data,
   output logic [1:0]      link_ch2_ctl
);
   initial begin
      link_clk = 1'h0;
      link_de = 1'h0;
      {link_ch2_data, link_ch1_data, link_ch0_data} = 24'h000000;
      {link_ch2_ctl, link_ch1_ctl, link_ch0_ctl} = 5'h00;
   end
   // c is {third, second, first control, vsync, hsync}; 64 ns per word, slower than nominal
   task automatic send(input logic de, input logic [23:0] px, input logic [4:0] c);
      begin
         link_de = de;
         {link_ch2_data, link_ch1_data, link_ch0_data} = px;
         {link_ch2_ctl, link_ch1_ctl, link_ch0_ctl} = c;
         #32 link_clk = 1'h1;
         #32 link_clk = 1'h0;
         // hold is over: the lines no longer carry the word
         {link_ch2_data, link_ch1_data, link_ch0_data} = ~px;
         {link_ch2_ctl, link_ch1_ctl, link_ch0_ctl} = ~c;
      end
   endtask
endmodule

/* verilog/dvr_fifo.sv */
// synchronous word fifo with valid/ready on both sides
// assumes one clock and a synchronised active-low reset
`timescale 1ns/1ns
module dvr_fifo #(
   parameter int WIDTH = 30,
   parameter int DEPTH = 16
) (
   input  wire logic clk,
   input  wire logic rst_n,
   dvr_stream_if.snk in_s,
   dvr_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             full;
   logic             empty;
   logic             do_wr;
   logic             do_rd;

   assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty       = (wr_ptr == rd_ptr);
   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem[rd_ptr[AW-1:0]];
   assign do_wr       = in_s.valid && !full;
   assign do_rd       = out_s.ready && !empty;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_s.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
      end else if (do_wr) begin
         wr_ptr <= wr_ptr + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= '0;
      end else if (do_rd) begin
         rd_ptr <= rd_ptr + (AW+1)'(1);
      end
   end
endmodule

/* verilog/dvr_pixel_out.sv */
// receiver pixel output: channel mapping, link activity, pixel pacing and stagger
// assumes decoded channel words synchronous to link_clk, mode pins asynchronous
//
// How it works
// - green from channel 1, first control bit in blank
// - red from channel 2, control bits two, three
// - link-active flag follows data enable toggling
// - stagger select active low, two-pixel mode only
// - stagger high: even and odd buses together
// - output clock period one or two pixels
// - mode select: two pixels or one per clock
// - shutdown floats outputs except flag, first control
// - blue and syncs from channel 0
`timescale 1ns/1ns
module dvr_pixel_out
   import dvr_pkg::*;
#(
   parameter int IDLE_TIMEOUT_CYCLES = LINK_IDLE_TIMEOUT_CYCLES
) (
   input  wire logic                 ref_clk,
   input  wire logic                 arst_n,
   input  wire logic                 link_clk,
   input  wire logic                 link_de,
   input  wire logic [CH_W-1:0]      link_ch0_data,
   input  wire logic [1:0]           link_ch0_ctl,
   input  wire logic [CH_W-1:0]      link_ch1_data,
   input  wire logic                 link_ch1_ctl,
   input  wire logic [CH_W-1:0]      link_ch2_data,
   input  wire logic [1:0]           link_ch2_ctl,
   input  wire logic                 pixels_per_clock_select,
   input  wire logic                 stagger_select_n,
   input  wire logic                 output_driver_shutdown_n,
   output logic [PIX_BUS_W-1:0]      even_pixel_bus,
   output logic [PIX_BUS_W-1:0]      odd_pixel_bus,
   output logic                      output_pixel_clock,
   output logic                      data_enable_out,
   output logic                      hsync_out,
   output logic                      vsync_out,
   output logic                      control_bit_first,
   output logic                      control_bit_second,
   output logic                      control_bit_third,
   output logic                      link_active_flag,
   output logic                      drivers_oe,
   output logic                      fifo_overflow
);
   logic [1:0]        rst_sync;
   logic              rst_n;
   logic [1:0]        link_rst_sync;
   logic              link_rst_n;
   logic [WORD_W-1:0] link_word;
   logic              link_tog;
   logic [1:0]        tog_sync;
   logic              tog_seen;
   logic              word_arrived;
   logic [2:0]        pin_s1;
   logic [2:0]        pin_s2;
   logic              pin_two_pix;
   logic              pin_stagger_select_n_n;
   logic              pin_pdo_n;
   logic              last_de;
   logic [31:0]       idle_cnt;
   dvr_out_state_t    state;
   logic [7:0]        half_cnt;
   logic              half_done;
   logic              mode_two;
   logic              mode_stagger_select_n;
   logic [WORD_W-1:0] even_stage;
   logic [WORD_W-1:0] odd_stage;
   logic              pop;

   dvr_stream_if #(.W(WORD_W)) push_s ();
   dvr_stream_if #(.W(WORD_W)) pop_s ();

   dvr_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .in_s  (push_s),
      .out_s (pop_s)
   );

   // reset release, one synchroniser per domain
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         link_rst_sync <= 2'h0;
      end else begin
         link_rst_sync <= {link_rst_sync[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_sync[1];

   // link domain: split channels into colour and control fields
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_word <= WORD_RESET;
         link_tog  <= 1'b0;
      end else begin
         link_tog          <= ~link_tog;
         link_word[F_DE]   <= link_de;
         if (link_de) begin
            link_word[F_BLUE_LSB +: CH_W]  <= link_ch0_data;
            link_word[F_GREEN_LSB +: CH_W] <= link_ch1_data;
            link_word[F_RED_LSB +: CH_W]   <= link_ch2_data;
         end else begin
            link_word[PIX_BUS_W-1:0] <= BUS_RESET;
            link_word[F_HSYNC]       <= link_ch0_ctl[0];
            link_word[F_VSYNC]       <= link_ch0_ctl[1];
            link_word[F_CONTROL_BIT_FIRST]        <= link_ch1_ctl;
            link_word[F_CONTROL_BIT_SECOND]        <= link_ch2_ctl[0];
            link_word[F_CONTROL_BIT_THIRD]        <= link_ch2_ctl[1];
         end
      end
   end

   // word crossing by toggle: the word holds one link period, which outlasts
   // the three ref cycles of the toggle path only while link period > 30 ns
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_sync <= 2'h0;
         tog_seen <= 1'b0;
      end else begin
         tog_sync <= {tog_sync[0], link_tog};
         tog_seen <= tog_sync[1];
      end
   end
   assign word_arrived = tog_sync[1] ^ tog_seen;
   assign push_s.valid = word_arrived;
   assign push_s.data  = link_word;

   // the fifo's ready stalls nothing upstream, so a refused word sets a sticky flag here
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_overflow <= 1'b0;
      end else if (word_arrived && !push_s.ready) begin
         fifo_overflow <= 1'b1;
      end
   end

   // asynchronous mode pins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 3'h5;
         pin_s2 <= 3'h5;
      end else begin
         pin_s1 <= {output_driver_shutdown_n, stagger_select_n, pixels_per_clock_select};
         pin_s2 <= pin_s1;
      end
   end
   assign pin_two_pix = pin_s2[0];
   assign pin_stagger_select_n_n  = pin_s2[1];
   assign pin_pdo_n   = pin_s2[2];

   // link activity: any edge of data enable rearms the idle timer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_de          <= 1'b0;
         idle_cnt         <= 32'h0000_0000;
         link_active_flag <= 1'b0;
      end else if (word_arrived && (link_word[F_DE] != last_de)) begin
         last_de          <= link_word[F_DE];
         idle_cnt         <= 32'h0000_0000;
         link_active_flag <= 1'b1;
      end else if (idle_cnt >= 32'(IDLE_TIMEOUT_CYCLES - 1)) begin
         link_active_flag <= 1'b0;
      end else begin
         idle_cnt <= idle_cnt + 32'h0000_0001;
      end
   end

   // output pacing: one output clock per popped pixel, or per popped pair
   assign half_done   = (half_cnt == 8'(OUT_HALF_CYCLES - 1));
   assign pop         = ((state == ST_FIRST) || (state == ST_SECOND)) && pop_s.valid;
   assign pop_s.ready = pop;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_FIRST;
         mode_two  <= 1'b0;
         mode_stagger_select_n <= 1'b0;
      end else begin
         case (state)
            ST_FIRST: begin
               if (pop_s.valid) begin
                  mode_two  <= pin_two_pix;
                  mode_stagger_select_n <= pin_two_pix && !pin_stagger_select_n_n;
                  state     <= pin_two_pix ? ST_SECOND : ST_LOW;
               end
            end
            ST_SECOND: begin
               if (pop_s.valid) begin
                  state <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_done) begin
                  state <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (half_done) begin
                  state <= ST_FIRST;
               end
            end
            default: begin
               state <= ST_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt <= 8'h00;
      end else if (((state == ST_LOW) || (state == ST_HIGH)) && !half_done) begin
         half_cnt <= half_cnt + 8'h01;
      end else begin
         half_cnt <= 8'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         even_stage <= WORD_RESET;
         odd_stage  <= WORD_RESET;
      end else if (pop && (state == ST_FIRST)) begin
         even_stage <= pop_s.data;
         odd_stage  <= WORD_RESET;
      end else if (pop) begin
         odd_stage  <= pop_s.data;
      end
   end

   // even bus and control bits change as the output clock falls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_pixel_clock <= 1'b0;
         even_pixel_bus     <= BUS_RESET;
         data_enable_out    <= 1'b0;
         hsync_out          <= 1'b0;
         vsync_out          <= 1'b0;
         control_bit_first  <= 1'b0;
         control_bit_second <= 1'b0;
         control_bit_third  <= 1'b0;
      end else if ((state == ST_LOW) && (half_cnt == 8'h00)) begin
         output_pixel_clock <= 1'b0;
         even_pixel_bus     <= even_stage[PIX_BUS_W-1:0];
         data_enable_out    <= even_stage[F_DE];
         hsync_out          <= even_stage[F_HSYNC];
         vsync_out          <= even_stage[F_VSYNC];
         control_bit_first  <= even_stage[F_CONTROL_BIT_FIRST];
         control_bit_second <= even_stage[F_CONTROL_BIT_SECOND];
         control_bit_third  <= even_stage[F_CONTROL_BIT_THIRD];
      end else if ((state == ST_HIGH) && (half_cnt == 8'h00)) begin
         output_pixel_clock <= 1'b1;
      end
   end

   // odd bus: with the even bus, or at the rising output clock two ref cycles later when staggered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         odd_pixel_bus <= BUS_RESET;
      end else if (!mode_two && (state == ST_LOW)) begin
         odd_pixel_bus <= BUS_RESET;
      end else if (!mode_stagger_select_n && (state == ST_LOW) && (half_cnt == 8'h00)) begin
         odd_pixel_bus <= odd_stage[PIX_BUS_W-1:0];
      end else if (mode_stagger_select_n && (state == ST_HIGH) && (half_cnt == 8'h00)) begin
         odd_pixel_bus <= odd_stage[PIX_BUS_W-1:0];
      end
   end

   // flag and first control bit stay driven; the rest float on shutdown
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         drivers_oe <= 1'b0;
      end else begin
         drivers_oe <= pin_pdo_n;
      end
   end
endmodule
